// *** design/chan_line_slice.sv ***
// Purpose: One channel's serial line pins: idle levels, modem pins, auto flow control.
// Assumes: Encoded infrared bit arrives from the channel's encoder.
// Notes: Pin outputs are registered; the transmit stall output is combinational.
`timescale 1ns/10ps
module chan_line_slice
   import pin_status_pkg::*;
(
   input wire logic mclk,
   input wire logic rst_n,
   chan_pins_if.slice p
);
   logic infrared_sel;
   logic auto_rts_on;
   logic auto_cts_on;
   logic so_next;
   logic ir_next;
   logic rts_next;

   // Mode and flow-control enables from the control bytes.
   assign infrared_sel = p.modem_ctrl[MC_INFRARED_BIT];
   assign auto_rts_on  = p.feature_ctrl[EF_AUTO_RTS_BIT] & p.irq_ctrl[IE_RTS_BIT];
   assign auto_cts_on  = p.feature_ctrl[EF_AUTO_CTS_BIT] & p.irq_ctrl[IE_CTS_BIT];
   // Idle is 1 in standard mode and 0 in infrared mode.
   assign so_next = infrared_sel ? (p.tx_active & p.ir_bit)
                                 : (p.tx_active ? p.tx_bit : 1'b1);
   // The dedicated infrared pin ignores the mode bit and idles low.
   assign ir_next = p.tx_active & p.ir_bit;
   // Auto mode drops request only while software has it asserted and the FIFO is full.
   assign rts_next = ~(p.modem_ctrl[MC_RTS_BIT] & ~(auto_rts_on & p.fifo_hold));
   // Clear to send doubles as a plain input; it stalls only in auto mode.
   assign p.tx_stall = auto_cts_on & p.cts_n;

   // Pin registers; reset gives standard idle levels.
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         p.serial_out          <= 1'b1;
         p.infrared_serial_out <= 1'b0;
         p.request_to_send_n   <= 1'b1;
         p.terminal_ready_n    <= 1'b1;
      end else begin
         p.serial_out          <= so_next;
         p.infrared_serial_out <= ir_next;
         p.request_to_send_n   <= rts_next;
         p.terminal_ready_n    <= ~p.modem_ctrl[MC_DTR_BIT];
      end
   end

   // Idle levels one edge after the line goes quiet, and the modem pin behaviour.
   a_ir_idle_low : assert property (@(posedge mclk) disable iff (!rst_n)
      !p.tx_active |=> !p.infrared_serial_out) else $error("infrared pin not low at idle");
   a_std_idle_high : assert property (@(posedge mclk) disable iff (!rst_n)
      (!infrared_sel && !p.tx_active) |=> p.serial_out) else $error("serial idle not high");
   a_ir_mode_idle : assert property (@(posedge mclk) disable iff (!rst_n)
      (infrared_sel && !p.tx_active) |=> !p.serial_out) else $error("infrared idle not low");
   a_cts_stall_auto : assert property (@(posedge mclk) disable iff (!rst_n)
      p.tx_stall |-> (auto_cts_on && p.cts_n)) else $error("stall without auto clear");
   a_dtr_follows : assert property (@(posedge mclk) disable iff (!rst_n)
      p.modem_ctrl[MC_DTR_BIT] |=> !p.terminal_ready_n) else $error("terminal ready stale");
endmodule // chan_line_slice

// *** design/quad_uart_pin_status_logic.sv ***
// Purpose: Pin-level control and status logic of a four-channel serial transceiver.
// Assumes: Inputs synchronous to mclk; control bytes come from the channel register files.
// Notes: Three-state pins are split into value and active-low output enable.
// What this block does
// - Force select high keeps interrupts enabled in strobe mode.
// - Force select low: modem bit 3 enables.
// - Bit 3 clear floats interrupt outputs unless force select holds them enabled.
// - Per-channel active-low transmit ready output.
// - Per-channel active-low receive ready output.
// - Combined transmit ready is AND of four.
// - Combined receive ready is AND of four.
// - Snapshot select drives snapshot onto data bus.
// - Bits 0-3 inverted tx, 4-7 rx.
// - Snapshot needs no address decode.
// - Standard mode: transmit idles and resets high.
// - Infrared mode: encoded data, idle low.
// - Infrared pin always encoded, idles low.
// - Clear-to-send general input or auto flow.
// - Terminal ready output under software control.
`timescale 1ns/10ps
module quad_uart_pin_status_logic
   import pin_status_pkg::*;
#(
   parameter int CHANNELS = NUM_CHAN
) (
   input  wire logic                  mclk,
   input  wire logic                  rst_n,
   input  wire logic                  bus_style_sel,
   input  wire logic                  irq_output_force_select,
   input  wire logic                  fifo_snapshot_select_n,
   input  wire logic [CHANNELS*8-1:0] modem_control_reg,
   input  wire logic [CHANNELS*8-1:0] enhanced_feature_reg,
   input  wire logic [CHANNELS*8-1:0] irq_enable_reg,
   input  wire logic [CHANNELS-1:0]   chan_irq,
   input  wire logic [CHANNELS-1:0]   tx_space,
   input  wire logic [CHANNELS-1:0]   rx_avail,
   input  wire logic [CHANNELS-1:0]   rx_fifo_hold,
   input  wire logic [CHANNELS-1:0]   tx_bit,
   input  wire logic [CHANNELS-1:0]   tx_active,
   input  wire logic [CHANNELS-1:0]   ir_bit,
   input  wire logic [CHANNELS-1:0]   serial_in,
   input  wire logic [CHANNELS-1:0]   clear_to_send_n,
   output logic      [CHANNELS-1:0]   irq_out,
   output logic      [CHANNELS-1:0]   irq_out_oe_n,
   output logic      [CHANNELS-1:0]   chan_tx_space_n,
   output logic      [CHANNELS-1:0]   chan_rx_avail_n,
   output logic                       combined_tx_space_n,
   output logic                       combined_rx_avail_n,
   output logic      [DATA_W-1:0]     data_out,
   output logic                       data_out_oe_n,
   output logic      [CHANNELS-1:0]   serial_in_level,
   output logic      [CHANNELS-1:0]   tx_stall,
   output logic      [CHANNELS-1:0]   serial_out,
   output logic      [CHANNELS-1:0]   infrared_serial_out,
   output logic      [CHANNELS-1:0]   request_to_send_n,
   output logic      [CHANNELS-1:0]   terminal_ready_n
);
   logic [CHANNELS-1:0] irq_en;
   logic [CHANNELS-1:0] tx_n_reg;
   logic [CHANNELS-1:0] rx_n_reg;
   logic                snap_sel;
   logic [DATA_W-1:0]   fifo_ready_snapshot;

   // Interrupt enable: the force select overrides modem bit 3 in strobe mode.
   // Single-select mode masks the force select with bus_style_sel, so only modem bit 3 decides.
   genvar gi;
   generate
      for (gi = 0; gi < CHANNELS; gi++) begin : g_chan
         chan_pins_if pins ();
         assign irq_en[gi] = (bus_style_sel & irq_output_force_select)
                           | modem_control_reg[gi*8+MC_IRQ_EN_BIT];
         assign pins.modem_ctrl   = modem_control_reg[gi*8 +: 8];
         assign pins.feature_ctrl = enhanced_feature_reg[gi*8 +: 8];
         assign pins.irq_ctrl     = irq_enable_reg[gi*8 +: 8];
         assign pins.tx_bit       = tx_bit[gi];
         assign pins.tx_active    = tx_active[gi];
         assign pins.ir_bit       = ir_bit[gi];
         assign pins.fifo_hold    = rx_fifo_hold[gi];
         assign pins.cts_n        = clear_to_send_n[gi];
         assign serial_out[gi]          = pins.serial_out;
         assign infrared_serial_out[gi] = pins.infrared_serial_out;
         assign request_to_send_n[gi]   = pins.request_to_send_n;
         assign terminal_ready_n[gi]    = pins.terminal_ready_n;
         assign tx_stall[gi]            = pins.tx_stall;
         chan_line_slice u_slice (
            .mclk  (mclk),
            .rst_n (rst_n),
            .p     (pins.slice)
         );
      end
   endgenerate

   // Snapshot ignores the address lines entirely; only the select matters.
   assign snap_sel = ~fifo_snapshot_select_n;
   assign fifo_ready_snapshot = {rx_n_reg, ~tx_n_reg};
   // Receive data passes straight through; its idle level is the partner's concern.
   assign serial_in_level = serial_in;
   // Handshake-like enables are combinational so the bus releases at once.
   assign data_out_oe_n = ~snap_sel;
   assign irq_out_oe_n  = ~irq_en;

   // Ready pin registers and combined versions.
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         tx_n_reg            <= '1;
         rx_n_reg            <= '1;
         combined_tx_space_n <= 1'b1;
         combined_rx_avail_n <= 1'b1;
         irq_out             <= '0;
         // The snapshot resets to the image of the idle ready pins, not to zero.
         data_out            <= {{CHANNELS{1'b1}}, {CHANNELS{1'b0}}};
      end else begin
         tx_n_reg            <= ~tx_space;
         rx_n_reg            <= ~rx_avail;
         combined_tx_space_n <= &(~tx_space);
         combined_rx_avail_n <= &(~rx_avail);
         irq_out             <= chan_irq;
         data_out            <= {~rx_avail, tx_space};
      end
   end
   assign chan_tx_space_n = tx_n_reg;
   assign chan_rx_avail_n = rx_n_reg;

   // Interrupt gating, ready pins and snapshot image; the snapshot must track the pins.
   a_irq_force_on : assert property (@(posedge mclk) disable iff (!rst_n)
      (bus_style_sel && irq_output_force_select) |-> (irq_out_oe_n == '0))
      else $error("forced interrupt outputs not enabled");
   a_irq_bit3_gate : assert property (@(posedge mclk) disable iff (!rst_n)
      !irq_output_force_select |-> (irq_out_oe_n[0] == !modem_control_reg[MC_IRQ_EN_BIT]))
      else $error("interrupt enable does not follow bit 3");
   a_irq_float : assert property (@(posedge mclk) disable iff (!rst_n)
      (!irq_output_force_select && !modem_control_reg[MC_IRQ_EN_BIT]) |-> irq_out_oe_n[0])
      else $error("interrupt driven while disabled");
   a_tx_ready_pin : assert property (@(posedge mclk) disable iff (!rst_n)
      1'b1 |=> (chan_tx_space_n == ~$past(tx_space))) else $error("tx ready wrong");
   a_rx_ready_pin : assert property (@(posedge mclk) disable iff (!rst_n)
      1'b1 |=> (chan_rx_avail_n == ~$past(rx_avail))) else $error("rx ready wrong");
   a_tx_combined : assert property (@(posedge mclk) disable iff (!rst_n)
      combined_tx_space_n == &chan_tx_space_n) else $error("combined tx wrong");
   a_rx_combined : assert property (@(posedge mclk) disable iff (!rst_n)
      combined_rx_avail_n == &chan_rx_avail_n) else $error("combined rx wrong");
   a_snap_layout : assert property (@(posedge mclk) disable iff (!rst_n)
      (data_out[SNAP_RX_LSB +: 4] == chan_rx_avail_n)
      && (data_out[SNAP_TX_LSB +: 4] == ~chan_tx_space_n)
      && (data_out == fifo_ready_snapshot))
      else $error("snapshot layout wrong");
   a_snap_release : assert property (@(posedge mclk) disable iff (!rst_n)
      $rose(fifo_snapshot_select_n) |-> data_out_oe_n) else $error("bus not released");
endmodule // quad_uart_pin_status_logic

// *** include/chan_pins_if.sv ***
// Purpose: Bundle of per-channel pin signals between the top and the channel slice.
// Assumes: One instance per channel.
// Notes: Plain levels only.
`timescale 1ns/10ps
interface chan_pins_if;
   logic [7:0] modem_ctrl;
   logic [7:0] feature_ctrl;
   logic [7:0] irq_ctrl;
   logic       tx_bit;
   logic       tx_active;
   logic       ir_bit;
   logic       fifo_hold;
   logic       cts_n;
   logic       serial_out;
   logic       infrared_serial_out;
   logic       request_to_send_n;
   logic       terminal_ready_n;
   logic       tx_stall;
   modport top   (output modem_ctrl, feature_ctrl, irq_ctrl, tx_bit, tx_active, ir_bit,
                  fifo_hold, cts_n,
                  input serial_out, infrared_serial_out, request_to_send_n,
                  terminal_ready_n, tx_stall);
   modport slice (input modem_ctrl, feature_ctrl, irq_ctrl, tx_bit, tx_active, ir_bit,
                  fifo_hold, cts_n,
                  output serial_out, infrared_serial_out, request_to_send_n,
                  terminal_ready_n, tx_stall);
endinterface

// *** include/pin_status_pkg.sv ***
// Purpose: Shared constants for the quad transceiver pin and status logic.
// Assumes: Four channels, eight-bit host data bus.
// Notes: Control bit positions index the per-channel control bytes.
package pin_status_pkg;
   localparam int NUM_CHAN        = 4;
   localparam int DATA_W          = 8;
   localparam int MC_RTS_BIT      = 1;    // Modem control: request to send.
   localparam int MC_DTR_BIT      = 0;    // Modem control: terminal ready.
   localparam int MC_IRQ_EN_BIT   = 3;    // Modem control: interrupt output enable.
   localparam int MC_INFRARED_BIT = 6;    // Modem control: infrared mode.
   localparam int EF_AUTO_RTS_BIT = 6;
   localparam int EF_AUTO_CTS_BIT = 7;
   localparam int IE_RTS_BIT      = 6;
   localparam int IE_CTS_BIT      = 7;
   localparam int SNAP_TX_LSB     = 0;    // Snapshot bits 0..3: inverted transmit ready.
   localparam int SNAP_RX_LSB     = 4;    // Snapshot bits 4..7: receive ready as is.
   localparam logic [7:0] CTRL_RESET = 8'h00;
endpackage

// *** tb/line_partner.sv ***
// Purpose: Far-side line model: remote receiver and transmitter of every channel.
// Assumes: Remote transmitter stays silent, standard signalling.
// Notes: Clear-to-send follows the bench's hold request one edge late.
`timescale 1ns/10ps
module line_partner (
   input  wire logic       mclk,
   input  wire logic       hold_off,
   output logic      [3:0] serial_in,
   output logic      [3:0] clear_to_send_n
);
   // The remote side sends nothing, so its line idles high.
   assign serial_in = 4'hF;
   // Registered, because a real peer never answers in the same cycle.
   always_ff @(posedge mclk) begin
      clear_to_send_n <= {4{hold_off}};
   end
endmodule // line_partner

// *** tb/quad_uart_pin_status_logic_tb.sv ***
// Purpose: Self-checking bench for the pin and status logic.
// Assumes: Control bytes are alike on all channels, except in the interrupt enable test.
// Notes: Inputs change 1 ns after the rising edge.
`timescale 1ns/10ps
module quad_uart_pin_status_logic_tb;
   import pin_status_pkg::*;
   logic        mclk = 1'h0, rst_n = 1'h0, bus_style_sel = 1'h1, irq_output_force_select = 1'h0;
   logic        fifo_snapshot_select_n = 1'h1, hold_off = 1'h0;
   logic [31:0] modem_control_reg = 32'h0, enhanced_feature_reg = 32'h0, irq_enable_reg = 32'h0;
   logic [3:0]  chan_irq = 4'h0, tx_space = 4'h0, rx_avail = 4'h0, rx_fifo_hold = 4'h0;
   logic [3:0]  tx_bit = 4'h0, tx_active = 4'h0, ir_bit = 4'h0, serial_in, clear_to_send_n;
   logic [3:0]  irq_out, irq_out_oe_n, chan_tx_space_n, chan_rx_avail_n, serial_in_level;
   logic [3:0]  tx_stall, serial_out, infrared_serial_out, request_to_send_n, terminal_ready_n;
   logic        combined_tx_space_n, combined_rx_avail_n, data_out_oe_n;
   logic [7:0]  data_out;
   int          n_mismatch = 0, n_tests = 0;
   // Clock at 125 MHz.
   always #4 mclk = ~mclk;
   quad_uart_pin_status_logic quad_uart_pin_status_logic_inst (.mclk, .rst_n, .bus_style_sel,
      .irq_output_force_select, .fifo_snapshot_select_n, .modem_control_reg,
      .enhanced_feature_reg, .irq_enable_reg, .chan_irq, .tx_space, .rx_avail, .rx_fifo_hold,
      .tx_bit, .tx_active, .ir_bit, .serial_in, .clear_to_send_n, .irq_out, .irq_out_oe_n,
      .chan_tx_space_n, .chan_rx_avail_n, .combined_tx_space_n, .combined_rx_avail_n,
      .data_out, .data_out_oe_n, .serial_in_level, .tx_stall, .serial_out,
      .infrared_serial_out, .request_to_send_n, .terminal_ready_n);
   line_partner line_partner_inst (.mclk, .hold_off, .serial_in, .clear_to_send_n);
   task automatic step();
      @(posedge mclk);
      #1;
   endtask
   task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
      n_tests++;
      if (got !== exp) begin
         n_mismatch++;
         $display("wrong value %s expected %h seen %h", name, exp, got);
      end
   endtask
   task automatic print_verdict();
      if (n_mismatch == 0 && n_tests > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   // Levels straight out of reset, before any control byte is written.
   task automatic t_reset();
      chk("serial_out", 8'h0F, 8'(serial_out));
      chk("ir_out", 8'h00, 8'(infrared_serial_out));
      chk("rts_n", 8'h0F, 8'(request_to_send_n));
      chk("dtr_n", 8'h0F, 8'(terminal_ready_n));
      chk("tx_n", 8'h0F, 8'(chan_tx_space_n));
      chk("rx_n", 8'h0F, 8'(chan_rx_avail_n));
      chk("all_n", 8'h03, 8'({combined_tx_space_n, combined_rx_avail_n}));
      chk("data_out", 8'hF0, data_out);
      chk("data_oe_n", 8'h01, 8'(data_out_oe_n));
      chk("irq", 8'h0F, 8'({irq_out, irq_out_oe_n}));
      chk("rx_level", 8'h0F, 8'(serial_in_level));
      chk("tx_stall", 8'h00, 8'(tx_stall));
   endtask
   // Force select overrides the enable bit; otherwise each channel's bit decides.
   // Combinational enables are looked at 1 ns after the inputs move, inputs only at edge+1.
   task automatic t_irq();
      chan_irq = 4'hA;
      irq_output_force_select = 1'h1;
      step();
      chk("irq_oe_n", 8'h00, 8'(irq_out_oe_n));
      chk("irq_out", 8'h0A, 8'(irq_out));
      irq_output_force_select = 1'h0;
      #1 chk("irq_oe_n", 8'h0F, 8'(irq_out_oe_n));
      step();
      modem_control_reg = 32'h0800_0800;
      chan_irq = 4'h5;
      #1 chk("irq_oe_n", 8'h05, 8'(irq_out_oe_n));
      step();
      chk("irq_out", 8'h05, 8'(irq_out));
      bus_style_sel = 1'h0;
      #1 chk("irq_oe_n", 8'h05, 8'(irq_out_oe_n));
      step();
      modem_control_reg = 32'h0;
      bus_style_sel = 1'h1;
   endtask
   // Mixed readiness, then a snapshot read and release of the bus.
   task automatic t_ready();
      tx_space = 4'h5;
      rx_avail = 4'h3;
      step();
      chk("tx_n", 8'h0A, 8'(chan_tx_space_n));
      chk("rx_n", 8'h0C, 8'(chan_rx_avail_n));
      chk("all_tx_n", 8'h00, 8'(combined_tx_space_n));
      chk("all_rx_n", 8'h00, 8'(combined_rx_avail_n));
      fifo_snapshot_select_n = 1'h0;
      step();
      chk("data_oe_n", 8'h00, 8'(data_out_oe_n));
      chk("data_out", 8'hC5, data_out);
      fifo_snapshot_select_n = 1'h1;
      #1 chk("data_oe_n", 8'h01, 8'(data_out_oe_n));
      step();
      tx_space = 4'h0;
      rx_avail = 4'h0;
      step();
      chk("all_tx_n", 8'h01, 8'(combined_tx_space_n));
      chk("all_rx_n", 8'h01, 8'(combined_rx_avail_n));
      chk("data_out", 8'hF0, data_out);
   endtask
   // Infrared-mode idle level, then live data on both transmit pins, then standard-mode idle.
   task automatic t_serial();
      modem_control_reg = {4{8'h40}};
      step();
      chk("serial_out", 8'h00, 8'(serial_out));
      tx_active = 4'hF;
      ir_bit = 4'h5;
      step();
      chk("serial_out", 8'h05, 8'(serial_out));
      chk("ir_out", 8'h05, 8'(infrared_serial_out));
      modem_control_reg = 32'h0;
      tx_bit = 4'h9;
      step();
      chk("serial_out", 8'h09, 8'(serial_out));
      chk("ir_out", 8'h05, 8'(infrared_serial_out));
      tx_active = 4'h0;
      step();
      chk("serial_out", 8'h0F, 8'(serial_out));
      chk("ir_out", 8'h00, 8'(infrared_serial_out));
   endtask
   // Software modem pins, then both automatic flow controls.
   task automatic t_modem();
      modem_control_reg = {4{8'h03}};
      rx_fifo_hold = 4'hF;
      step();
      chk("rts_n", 8'h00, 8'(request_to_send_n));
      chk("dtr_n", 8'h00, 8'(terminal_ready_n));
      enhanced_feature_reg = {4{8'hC0}};
      irq_enable_reg = {4{8'hC0}};
      hold_off = 1'h1;
      step();
      step();
      chk("rts_n", 8'h0F, 8'(request_to_send_n));
      chk("tx_stall", 8'h0F, 8'(tx_stall));
      hold_off = 1'h0;
      rx_fifo_hold = 4'h0;
      step();
      step();
      chk("tx_stall", 8'h00, 8'(tx_stall));
      chk("rts_n", 8'h00, 8'(request_to_send_n));
   endtask
   // Main sequence; a hang is cut short by the watchdog.
   initial begin
      repeat (12) step();
      rst_n = 1;
      t_reset();
      t_irq();
      t_ready();
      t_serial();
      t_modem();
      print_verdict();
   end
   initial begin
      #40000;
      n_mismatch++;
      print_verdict();
   end
endmodule // quad_uart_pin_status_logic_tb
